//--- core/sfc_pkg.sv
// constants, field positions and types shared by the gate-driver control block
// assumes a 50 MHz core clock; register data words are 11 bits wide
package sfc_pkg;

  localparam int DATA_W = 11;
  localparam int ADDR_W = 4;
  localparam int WORD_W = 16;
  localparam int REG_CNT = 16;
  localparam int BANK_W = DATA_W * REG_CNT;

  // register addresses
  localparam logic [3:0] ADDR_WARN = 4'h1;
  localparam logic [3:0] ADDR_VDS_FLT = 4'h2;
  localparam logic [3:0] ADDR_IC_FLT = 4'h3;
  localparam logic [3:0] ADDR_VGS_FLT = 4'h4;
  localparam logic [3:0] ADDR_HS_GATE = 4'h5;
  localparam logic [3:0] ADDR_LS_GATE = 4'h6;
  localparam logic [3:0] ADDR_IC_OP = 4'h9;
  localparam logic [3:0] ADDR_VREG = 4'hb;
  localparam logic [3:0] ADDR_VDS_CTRL = 4'hc;

  // frame word layout
  localparam int RW_POS = 15;
  localparam int ADDR_LSB = 11;
  localparam int DC_BITS = 5;

  // status bit positions
  localparam int WARN_FAULT_POS = 10;
  localparam int IC_LOCK_POS = 10;
  localparam int IC_TEMP_POS = 8;
  localparam int IC_UV_POS = 6;
  localparam int VDS_DRAIN_POS = 10;
  localparam int VDS_SENSE_POS = 0;
  localparam int VGS_GATE_POS = 10;

  // control bit positions
  localparam int OP_TEMP_DIS_POS = 10;
  localparam int OP_LOCK_DIS_POS = 9;
  localparam int OP_GATE_DIS_POS = 8;
  localparam int OP_SENSE_DIS_POS = 4;
  localparam int OP_SLEEP_POS = 2;
  localparam int OP_CLR_POS = 1;
  localparam int REG_UNDERVOLTAGE_FLAG_SEL_LSB = 0;
  localparam int REG_UNDERVOLTAGE_FLAG_DIS_POS = 2;
  localparam int VREG_SLP_LSB = 3;
  localparam int DRAIN_OC_MODE_LSB = 0;

  // reset values of the control registers
  localparam logic [10:0] RST_GATE_CFG = 11'h000;
  localparam logic [10:0] RST_IC_OP = 11'h000;
  localparam logic [10:0] RST_VREG = 11'h000;
  localparam logic [10:0] RST_VDS = 11'h000;

  // timing
  localparam int CORE_CLK_NS = 20;
  localparam int PG_LOW_NS = 56000;
  localparam int PG_LOW_CYC = (PG_LOW_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int PG_CNT_W = 12;

  typedef enum logic [2:0] {
    OC_LATCH = 3'h0,
    OC_REPORT = 3'h1,
    OC_OFF = 3'h2
  } sfc_oc_mode_e;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_STANDBY = 3'h1,
    ST_OPERATE = 3'h2,
    ST_SLEEP_WAIT = 3'h3,
    ST_SLEEP = 3'h4
  } sfc_state_e;

endpackage

//--- core/sfc_spi_link.sv
// serial link end of the control block, clocked by the master's serial clock
// assumes clock idle low and no clock edges while the select is high
`timescale 1ns/1ps
module sfc_spi_link (
  input wire logic rst,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic sdi,
  input wire logic [sfc_pkg::BANK_W-1:0] rd_bank,
  output logic sdo,
  output logic sdo_oe,
  output logic [sfc_pkg::WORD_W-1:0] word,
  output logic word_tgl,
  output logic excess_tgl
);

  logic [4:0] fall_cnt_r;
  logic [sfc_pkg::WORD_W-2:0] shift_r;
  logic [sfc_pkg::DATA_W-1:0] out_r;

  function automatic logic [3:0] out_idx(input logic [4:0] cnt);
    out_idx = 4'(5'h0f - cnt);
  endfunction

  // select high clears the frame state, so clock noise between frames is ignored
  always_ff @(negedge sclk or posedge select_n) begin
    if (select_n) begin
      fall_cnt_r <= 5'h00;
      shift_r <= '0;
      out_r <= '0;
    end else begin
      shift_r <= {shift_r[sfc_pkg::WORD_W-3:0], sdi};
      if (fall_cnt_r != 5'h1f) begin
        fall_cnt_r <= fall_cnt_r + 5'h01;
      end
      if (fall_cnt_r == 5'h04) begin
        out_r <= rd_bank[{shift_r[2:0], sdi} * sfc_pkg::DATA_W +: sfc_pkg::DATA_W];
      end
    end
  end

  // word and toggles survive the select going high; the core picks them up
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      word <= '0;
      word_tgl <= 1'b0;
      excess_tgl <= 1'b0;
    end else if (!select_n) begin
      if (fall_cnt_r == 5'h0f) begin
        word <= {shift_r, sdi};
        word_tgl <= ~word_tgl;
      end
      if (fall_cnt_r == 5'h10) begin
        excess_tgl <= ~excess_tgl;
      end
    end
  end

  // first five bits are don't-care zeros, then register data msb first
  always_ff @(posedge sclk or posedge select_n) begin
    if (select_n) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= 1'b1;
      if (fall_cnt_r >= 5'(sfc_pkg::DC_BITS) && fall_cnt_r <= 5'h0f) begin
        sdo <= out_r[out_idx(fall_cnt_r)];
      end else begin
        sdo <= 1'b0;
      end
    end
  end

endmodule

//--- core/sfc_sync.sv
// two-stage level synchroniser for a bundle of independent single-bit inputs
// assumes each bit is a level; bits are not coherent with each other
`timescale 1ns/1ps
module sfc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  initial begin
    if (WIDTH < 1) begin
      $error("sfc_sync width must be at least 1");
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- core/sfc_fault_state_ctrl.sv
// top of the gate-driver control logic: serial register access, state machine
// and latched fault handling; analog monitors arrive as raw level inputs
`timescale 1ns/1ps
module sfc_fault_state_ctrl #(
  parameter int SLEEP_UNIT_CYC = 5000
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SPI_CLK,
  input wire logic SPI_SELECT_N,
  input wire logic SPI_DATA_IN,
  output logic SPI_DATA_OUT,
  output logic SPI_DATA_OUT_OE,
  input wire logic GATE_EN,
  input wire logic WAKE,
  input wire logic DRIVER_SUPPLY_LOCKOUT_OK,
  input wire logic REG_UNDERVOLTAGE_DET,
  input wire logic GATE_FAULT_DET,
  input wire logic SENSE_OC_DET,
  input wire logic OVERTEMP_DET,
  input wire logic DRAIN_OC_DET,
  output logic POWER_GOOD_OUT,
  output logic FAULT_OUT_N,
  output logic GATE_DRIVE_EN,
  output logic PULLDOWN_EN,
  output logic AMP_EN,
  output logic REGULATOR_EN,
  output logic [1:0] REG_UV_THRESHOLD_SEL,
  output logic REG_UV_MONITOR_DISABLE,
  output logic [10:0] HS_GATE_CFG,
  output logic [10:0] LS_GATE_CFG,
  output logic [2:0] DRAIN_OC_MODE,
  output logic [7:0] DRAIN_OC_THRESHOLD
);

  localparam int SLP_W = 16;

  initial begin
    if (SLEEP_UNIT_CYC < 1 || SLEEP_UNIT_CYC * 4 >= (1 << SLP_W)) begin
      $error("SLEEP_UNIT_CYC out of range");
    end
  end

  // link side, on the serial clock
  logic [sfc_pkg::BANK_W-1:0] rd_bank;
  logic [sfc_pkg::WORD_W-1:0] link_word;
  logic link_word_tgl;
  logic link_excess_tgl;

  sfc_spi_link u_link (
    .rst(RST),
    .sclk(SPI_CLK),
    .select_n(SPI_SELECT_N),
    .sdi(SPI_DATA_IN),
    .rd_bank(rd_bank),
    .sdo(SPI_DATA_OUT),
    .sdo_oe(SPI_DATA_OUT_OE),
    .word(link_word),
    .word_tgl(link_word_tgl),
    .excess_tgl(link_excess_tgl)
  );

  // every pin level and link toggle passes two flops before use; the link word is read directly
  logic [10:0] sync_s;

  sfc_sync #(
    .WIDTH(11)
  ) u_sync (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .async_in({SPI_SELECT_N, link_word_tgl, link_excess_tgl, GATE_EN, WAKE,
      DRIVER_SUPPLY_LOCKOUT_OK, REG_UNDERVOLTAGE_DET, GATE_FAULT_DET,
      SENSE_OC_DET, OVERTEMP_DET, DRAIN_OC_DET}),
    .sync_out(sync_s)
  );

  logic sel_n_s;
  logic word_tgl_s;
  logic excess_tgl_s;
  logic gate_en_s;
  logic wake_s;
  logic supply_ok_s;
  logic uv_det_s;
  logic gate_det_s;
  logic sense_det_s;
  logic temp_det_s;
  logic drain_det_s;

  assign {sel_n_s, word_tgl_s, excess_tgl_s, gate_en_s, wake_s, supply_ok_s,
    uv_det_s, gate_det_s, sense_det_s, temp_det_s, drain_det_s} = sync_s;

  // frame completion
  logic sel_d1_r;
  logic sel_d2_r;
  logic word_seen_r;
  logic excess_seen_r;
  logic frame_end;
  logic frame_ok;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [10:0] wr_data;

  // judged one cycle after the select rise, so a toggle that landed one
  // sample behind the select is still counted
  assign frame_end = sel_d1_r & ~sel_d2_r;
  assign frame_ok = frame_end && (word_tgl_s != word_seen_r)
    && (excess_tgl_s == excess_seen_r);
  assign wr_en = frame_ok && !link_word[sfc_pkg::RW_POS];
  assign wr_addr = link_word[sfc_pkg::RW_POS-1:sfc_pkg::ADDR_LSB];
  assign wr_data = link_word[sfc_pkg::DATA_W-1:0];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sel_d1_r <= 1'b1;
      sel_d2_r <= 1'b1;
      word_seen_r <= 1'b0;
      excess_seen_r <= 1'b0;
    end else begin
      sel_d1_r <= sel_n_s;
      sel_d2_r <= sel_d1_r;
      if (frame_end) begin
        word_seen_r <= word_tgl_s;
        excess_seen_r <= excess_tgl_s;
      end
    end
  end

  // state and control registers
  sfc_pkg::sfc_state_e state_r;
  sfc_pkg::sfc_state_e state_nxt;
  logic [10:0] hs_gate_r;
  logic [10:0] ls_gate_r;
  logic [10:0] ic_op_r;
  logic [10:0] vreg_r;
  logic [10:0] vds_r;
  logic clr_req_r;
  logic gate_en_d_r;
  logic en_rise;
  logic sleep_go;
  logic sleep_enter;
  logic [SLP_W-1:0] sleep_cnt_r;

  assign en_rise = gate_en_s & ~gate_en_d_r;
  assign sleep_go = wr_en && wr_addr == sfc_pkg::ADDR_IC_OP
    && wr_data[sfc_pkg::OP_SLEEP_POS]
    && state_r == sfc_pkg::ST_STANDBY && !gate_en_s;
  assign sleep_enter = state_r == sfc_pkg::ST_SLEEP_WAIT && sleep_cnt_r == '0;

  // fault conditions, each gated by its disable
  logic uv_cond;
  logic lock_cond;
  logic gate_cond;
  logic sense_cond;
  logic temp_cond;
  logic drain_cond;
  logic any_cond;
  logic clr_go;
  logic [5:0] flt_r;
  logic [5:0] cond_vec;
  logic fault_any;

  assign uv_cond = uv_det_s && !vreg_r[sfc_pkg::REG_UNDERVOLTAGE_FLAG_DIS_POS];
  assign lock_cond = !supply_ok_s && !ic_op_r[sfc_pkg::OP_LOCK_DIS_POS]
    && state_r != sfc_pkg::ST_POWERUP && state_r != sfc_pkg::ST_SLEEP;
  assign gate_cond = gate_det_s && !ic_op_r[sfc_pkg::OP_GATE_DIS_POS];
  assign sense_cond = sense_det_s && !ic_op_r[sfc_pkg::OP_SENSE_DIS_POS];
  assign temp_cond = temp_det_s && !ic_op_r[sfc_pkg::OP_TEMP_DIS_POS];
  // report-only and disabled modes never latch
  assign drain_cond = drain_det_s
    && vds_r[2:0] == sfc_pkg::OC_LATCH;
  assign cond_vec = {uv_cond, lock_cond, gate_cond, sense_cond, temp_cond, drain_cond};
  assign any_cond = |cond_vec;
  assign clr_go = (clr_req_r || en_rise) && !any_cond;
  assign fault_any = |flt_r;

  // a condition present in the clearing cycle keeps its latch
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      flt_r <= '0;
    end else begin
      flt_r <= cond_vec | (flt_r & {6{~clr_go}});
    end
  end

  // clear request stays pending until every condition has gone or sleep is entered
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      clr_req_r <= 1'b0;
    end else if (wr_en && wr_addr == sfc_pkg::ADDR_IC_OP
        && wr_data[sfc_pkg::OP_CLR_POS]) begin
      clr_req_r <= 1'b1;
    end else if (clr_go || sleep_enter) begin
      clr_req_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      gate_en_d_r <= 1'b0;
    end else begin
      gate_en_d_r <= gate_en_s;
    end
  end

  function automatic logic [SLP_W-1:0] sleep_cycles(input logic [1:0] sel);
    sleep_cycles = SLP_W'((int'(sel) + 1) * SLEEP_UNIT_CYC);
  endfunction

  // register writes, applied once the frame has closed
  always_ff @(posedge CORE_CLK) begin
    if (RST || sleep_enter) begin
      hs_gate_r <= sfc_pkg::RST_GATE_CFG;
      ls_gate_r <= sfc_pkg::RST_GATE_CFG;
      ic_op_r <= sfc_pkg::RST_IC_OP;
      vreg_r <= sfc_pkg::RST_VREG;
      vds_r <= sfc_pkg::RST_VDS;
    end else if (wr_en) begin
      unique case (wr_addr)
        sfc_pkg::ADDR_HS_GATE: hs_gate_r <= wr_data;
        sfc_pkg::ADDR_LS_GATE: ls_gate_r <= wr_data;
        sfc_pkg::ADDR_IC_OP: begin
          ic_op_r <= wr_data;
          ic_op_r[sfc_pkg::OP_SLEEP_POS] <= 1'b0;
          ic_op_r[sfc_pkg::OP_CLR_POS] <= 1'b0;
        end
        sfc_pkg::ADDR_VREG: vreg_r <= wr_data;
        sfc_pkg::ADDR_VDS_CTRL: begin
          vds_r[10:3] <= wr_data[10:3];
          if (state_r != sfc_pkg::ST_OPERATE
              || wr_data[2:0] == sfc_pkg::OC_OFF) begin
            vds_r[2:0] <= wr_data[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // operating state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sfc_pkg::ST_POWERUP: begin
        if (supply_ok_s) begin
          state_nxt = sfc_pkg::ST_STANDBY;
        end
      end
      sfc_pkg::ST_STANDBY: begin
        if (sleep_go) begin
          state_nxt = sfc_pkg::ST_SLEEP_WAIT;
        end else if (en_rise && !fault_any && !any_cond) begin
          state_nxt = sfc_pkg::ST_OPERATE;
        end
      end
      sfc_pkg::ST_OPERATE: begin
        if (!gate_en_s || fault_any || any_cond) begin
          state_nxt = sfc_pkg::ST_STANDBY;
        end
      end
      sfc_pkg::ST_SLEEP_WAIT: begin
        if (sleep_cnt_r == '0) begin
          state_nxt = sfc_pkg::ST_SLEEP;
        end
      end
      sfc_pkg::ST_SLEEP: begin
        if (wake_s && supply_ok_s) begin
          state_nxt = sfc_pkg::ST_POWERUP;
        end
      end
      default: state_nxt = sfc_pkg::ST_POWERUP;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_r <= sfc_pkg::ST_POWERUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sleep_cnt_r <= '0;
    end else if (sleep_go) begin
      sleep_cnt_r <= sleep_cycles(vreg_r[sfc_pkg::VREG_SLP_LSB +: 2]);
    end else if (state_r == sfc_pkg::ST_SLEEP_WAIT && sleep_cnt_r != '0) begin
      sleep_cnt_r <= sleep_cnt_r - SLP_W'(1);
    end
  end

  // power good hold-off, restarted by every undervoltage sample unless the monitor is disabled
  logic [sfc_pkg::PG_CNT_W-1:0] pg_cnt_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pg_cnt_r <= '0;
    end else if (uv_cond) begin
      pg_cnt_r <= sfc_pkg::PG_CNT_W'(sfc_pkg::PG_LOW_CYC - 1);
    end else if (pg_cnt_r != '0) begin
      pg_cnt_r <= pg_cnt_r - sfc_pkg::PG_CNT_W'(1);
    end
  end

  // outputs, all registered
  logic driving;
  logic asleep;

  assign driving = state_nxt == sfc_pkg::ST_OPERATE;
  assign asleep = state_nxt == sfc_pkg::ST_SLEEP;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      POWER_GOOD_OUT <= 1'b0;
      FAULT_OUT_N <= 1'b0;
      GATE_DRIVE_EN <= 1'b0;
      PULLDOWN_EN <= 1'b1;
      AMP_EN <= 1'b0;
      REGULATOR_EN <= 1'b1;
    end else begin
      POWER_GOOD_OUT <= !uv_cond && pg_cnt_r == '0 && !asleep;
      FAULT_OUT_N <= state_nxt != sfc_pkg::ST_POWERUP
        && !fault_any && !any_cond;
      GATE_DRIVE_EN <= driving && !any_cond;
      AMP_EN <= driving && !any_cond;
      PULLDOWN_EN <= !driving && !asleep;
      REGULATOR_EN <= !asleep;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      REG_UV_THRESHOLD_SEL <= 2'h0;
      REG_UV_MONITOR_DISABLE <= 1'b0;
      HS_GATE_CFG <= sfc_pkg::RST_GATE_CFG;
      LS_GATE_CFG <= sfc_pkg::RST_GATE_CFG;
      DRAIN_OC_MODE <= sfc_pkg::OC_LATCH;
      DRAIN_OC_THRESHOLD <= 8'h00;
    end else begin
      REG_UV_THRESHOLD_SEL <= vreg_r[sfc_pkg::REG_UNDERVOLTAGE_FLAG_SEL_LSB +: 2];
      REG_UV_MONITOR_DISABLE <= vreg_r[sfc_pkg::REG_UNDERVOLTAGE_FLAG_DIS_POS];
      HS_GATE_CFG <= hs_gate_r;
      LS_GATE_CFG <= ls_gate_r;
      DRAIN_OC_MODE <= vds_r[2:0];
      DRAIN_OC_THRESHOLD <= vds_r[10:3];
    end
  end

  // read bank: slow-changing words sampled by the link mid-frame
  always_comb begin
    rd_bank = '0;
    rd_bank[sfc_pkg::ADDR_WARN * sfc_pkg::DATA_W + sfc_pkg::WARN_FAULT_POS] = fault_any;
    rd_bank[sfc_pkg::ADDR_VDS_FLT * sfc_pkg::DATA_W + sfc_pkg::VDS_DRAIN_POS] = flt_r[0];
    rd_bank[sfc_pkg::ADDR_VDS_FLT * sfc_pkg::DATA_W + sfc_pkg::VDS_SENSE_POS] = flt_r[2];
    rd_bank[sfc_pkg::ADDR_IC_FLT * sfc_pkg::DATA_W + sfc_pkg::IC_LOCK_POS] = flt_r[4];
    rd_bank[sfc_pkg::ADDR_IC_FLT * sfc_pkg::DATA_W + sfc_pkg::IC_TEMP_POS] = flt_r[1];
    rd_bank[sfc_pkg::ADDR_IC_FLT * sfc_pkg::DATA_W + sfc_pkg::IC_UV_POS] = flt_r[5];
    rd_bank[sfc_pkg::ADDR_VGS_FLT * sfc_pkg::DATA_W + sfc_pkg::VGS_GATE_POS] = flt_r[3];
    rd_bank[sfc_pkg::ADDR_HS_GATE * sfc_pkg::DATA_W +: sfc_pkg::DATA_W] = hs_gate_r;
    rd_bank[sfc_pkg::ADDR_LS_GATE * sfc_pkg::DATA_W +: sfc_pkg::DATA_W] = ls_gate_r;
    rd_bank[sfc_pkg::ADDR_IC_OP * sfc_pkg::DATA_W +: sfc_pkg::DATA_W] = ic_op_r;
    rd_bank[sfc_pkg::ADDR_IC_OP * sfc_pkg::DATA_W + sfc_pkg::OP_CLR_POS] = clr_req_r;
    rd_bank[sfc_pkg::ADDR_VREG * sfc_pkg::DATA_W +: sfc_pkg::DATA_W] = vreg_r;
    rd_bank[sfc_pkg::ADDR_VDS_CTRL * sfc_pkg::DATA_W +: sfc_pkg::DATA_W] = vds_r;
  end

endmodule

//--- tb/sfc_props.sv
// concurrent checks on the gate-driver control top, bound to every instance
// assumes all checks are judged on the core clock; link timing shows at the pins
`timescale 1ns/1ps
module sfc_props (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SPI_SELECT_N,
  input wire logic SPI_DATA_OUT_OE,
  input wire logic GATE_EN,
  input wire logic REG_UNDERVOLTAGE_DET,
  input wire logic REG_UV_MONITOR_DISABLE,
  input wire logic POWER_GOOD_OUT,
  input wire logic FAULT_OUT_N,
  input wire logic GATE_DRIVE_EN,
  input wire logic PULLDOWN_EN,
  input wire logic AMP_EN,
  input wire logic REGULATOR_EN,
  input wire logic [10:0] HS_GATE_CFG,
  input wire logic [10:0] LS_GATE_CFG,
  input wire logic [2:0] DRAIN_OC_MODE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // cycles since the last undervoltage sample, saturating
  logic uv_seen_r;
  logic [11:0] uv_cnt_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      uv_seen_r <= 1'b0;
      uv_cnt_r <= 12'h000;
    end else if (REG_UNDERVOLTAGE_DET && !REG_UV_MONITOR_DISABLE) begin
      uv_seen_r <= 1'b1;
      uv_cnt_r <= 12'h000;
    end else begin
      if (uv_cnt_r != 12'hfff) uv_cnt_r <= uv_cnt_r + 12'h001;
      // margin so the first cycles of a fault do not clear the flag
      if (POWER_GOOD_OUT && uv_cnt_r > 12'h010) uv_seen_r <= 1'b0;
    end
  end

  property p_sel_hiz;
    SPI_SELECT_N |-> !SPI_DATA_OUT_OE;
  endproperty
  a_sel_hiz: assert property (p_sel_hiz) else $error("output enabled while deselected");

  property p_uv_pg;
    (REG_UNDERVOLTAGE_DET && !REG_UV_MONITOR_DISABLE) [*2]
      |-> ##[1:5] (!POWER_GOOD_OUT && !FAULT_OUT_N);
  endproperty
  a_uv_pg: assert property (p_uv_pg) else $error("undervoltage not flagged");

  property p_uv_off;
    (REG_UNDERVOLTAGE_DET && !REG_UV_MONITOR_DISABLE) [*2]
      |-> ##[1:5] (!GATE_DRIVE_EN && PULLDOWN_EN);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("drivers on during undervoltage");

  property p_pg_min;
    $rose(POWER_GOOD_OUT) && uv_seen_r |-> uv_cnt_r >= 12'(sfc_pkg::PG_LOW_CYC);
  endproperty
  a_pg_min: assert property (p_pg_min) else $error("power good low too short");

  property p_drive_pair;
    GATE_DRIVE_EN |-> AMP_EN && !PULLDOWN_EN && REGULATOR_EN;
  endproperty
  a_drive_pair: assert property (p_drive_pair) else $error("drive outputs disagree");

  property p_gate_low;
    !GATE_EN [*6] |-> !GATE_DRIVE_EN;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("driving with enable low");

  property p_op_entry;
    $rose(GATE_DRIVE_EN) |-> $past(GATE_EN, 3);
  endproperty
  a_op_entry: assert property (p_op_entry) else $error("operate without enable");

  property p_sleep_clr;
    $fell(REGULATOR_EN) |-> ##[0:2] (HS_GATE_CFG == 11'h000 && LS_GATE_CFG == 11'h000
      && DRAIN_OC_MODE == 3'h0 && !GATE_DRIVE_EN);
  endproperty
  a_sleep_clr: assert property (p_sleep_clr) else $error("sleep kept settings");

  property p_mode_lock;
    GATE_DRIVE_EN && $past(GATE_DRIVE_EN, 2) && $changed(DRAIN_OC_MODE)
      |-> DRAIN_OC_MODE == 3'h2;
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("illegal mode change");

  c_uv: cover property ($fell(POWER_GOOD_OUT));
  c_op: cover property ($rose(GATE_DRIVE_EN));
  c_sleep: cover property ($fell(REGULATOR_EN));
endmodule

bind sfc_fault_state_ctrl sfc_props i_props (.*);

//--- tb/sfc_spi_master.sv
// controller model driving the register link as serial master
// assumes the device samples on falling clock edges and answers on rising ones
`timescale 1ns/1ps
module sfc_spi_master (
  output logic sclk,
  output logic sel_n,
  output logic sdi,
  input wire logic sdo
);
  // a real rising select edge, so the link's asynchronous clear is not lost at time zero
  initial begin
    sclk = 1'b0;
    sel_n = 1'b0;
    sdi = 1'b0;
    #2;
    sel_n = 1'b1;
  end

  // clock stands low outside frames; nclk other than 16 makes a bad frame
  task automatic xfer(input int nclk, input logic [15:0] word, output logic [15:0] rd);
    rd = 16'h0000;
    #600;
    sel_n = 1'b0;
    #40;
    for (int i = 0; i < nclk; i++) begin
      sclk = 1'b1;
      sdi = word[15 - (i % 16)];
      #15;
      sclk = 1'b0;
      rd = {rd[14:0], sdo};
      #15;
    end
    #25;
    sel_n = 1'b1;
    // released line must not keep a stale level
    sdi = ~sdi;
  endtask
endmodule

//--- tb/tb_spi_fault_state_ctrl.sv
// self-checking bench for the gate-driver control top
// assumes the link master model and the bound checker sit beside the design
`timescale 1ns/1ps
module tb_spi_fault_state_ctrl;
  localparam int UNIT = 10;
  logic CORE_CLK, RST, SPI_CLK, SPI_SELECT_N, SPI_DATA_IN, SPI_DATA_OUT, SPI_DATA_OUT_OE;
  logic GATE_EN, WAKE, DRIVER_SUPPLY_LOCKOUT_OK, REG_UNDERVOLTAGE_DET, POWER_GOOD_OUT;
  logic FAULT_OUT_N, GATE_DRIVE_EN, PULLDOWN_EN, AMP_EN, REGULATOR_EN, REG_UV_MONITOR_DISABLE;
  logic [1:0] REG_UV_THRESHOLD_SEL;
  logic [10:0] HS_GATE_CFG, LS_GATE_CFG;
  logic [2:0] DRAIN_OC_MODE;
  logic [7:0] DRAIN_OC_THRESHOLD;
  logic GATE_FAULT_DET;
  int fails = 0;
  int comparisons = 0;
  integer seed = 27515;
  int n;
  int e;
  logic [10:0] sh [16];
  logic [15:0] r;
  logic [10:0] d;
  logic [3:0] a;
  logic [1:0] sel;
  logic [2:0] ms [3] = '{3'h0, 3'h1, 3'h2};

  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  sfc_spi_master i_mst (.sclk(SPI_CLK), .sel_n(SPI_SELECT_N), .sdi(SPI_DATA_IN), .sdo(SPI_DATA_OUT));

  sfc_fault_state_ctrl #(.SLEEP_UNIT_CYC(UNIT)) i_dut (
    .SENSE_OC_DET(1'b0),
    .OVERTEMP_DET(1'b0),
    .DRAIN_OC_DET(1'b0),
    .*
  );

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge CORE_CLK);
  endtask

  task automatic xfer(input int nclk, input logic rw, input logic [3:0] ad, input logic [10:0] dt);
    i_mst.xfer(nclk, {rw, ad, dt}, r);
    cyc(6);
  endtask

  task automatic pg_wait;
    n = 0;
    while (POWER_GOOD_OUT !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
  endtask

  // mode writes while driving may only switch the monitor off
  function automatic logic [2:0] exp_mode(input logic [2:0] cur, input logic [2:0] nw);
    return (nw != sfc_pkg::OC_OFF) ? cur : nw;
  endfunction

  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge CORE_CLK);
    fails++;
    complete_run;
  end

  initial begin
    RST = 1'b0;
    GATE_EN = 1'b0;
    WAKE = 1'b0;
    DRIVER_SUPPLY_LOCKOUT_OK = 1'b0;
    REG_UNDERVOLTAGE_DET = 1'b0;
    GATE_FAULT_DET = 1'b0;
    // a real reset edge, so the link-side asynchronous reset fires
    #1;
    RST = 1'b1;
    for (int i = 0; i < 16; i++) sh[i] = 11'h000;
    cyc(5);
    RST <= 1'b0;
    cyc(10);
    chk({FAULT_OUT_N, PULLDOWN_EN, REGULATOR_EN}, 11'h003);
    DRIVER_SUPPLY_LOCKOUT_OK <= 1'b1;
    cyc(10);
    chk({FAULT_OUT_N, PULLDOWN_EN, GATE_DRIVE_EN, SPI_DATA_OUT_OE}, 11'h00c);
    for (int i = 0; i < 9; i++) begin
      a = (i % 3 == 0) ? 4'h5 : (i % 3 == 1) ? 4'h6 : 4'hb;
      d = 11'($random(seed));
      if (a == 4'hb) d = d & 11'h01b;
      xfer(16, 1'b0, a, d);
      chk(r[10:0], sh[a]);
      sh[a] = d;
      xfer(16, 1'b1, a, 11'h000);
      chk(r[10:0], d);
    end
    chk(HS_GATE_CFG, sh[5]);
    chk(LS_GATE_CFG, sh[6]);
    chk({REG_UV_MONITOR_DISABLE, REG_UV_THRESHOLD_SEL}, sh[11] & 11'h007);
    xfer(15, 1'b0, 4'h5, ~sh[5]);
    xfer(17, 1'b0, 4'h5, ~sh[5]);
    xfer(16, 1'b1, 4'h5, 11'h000);
    chk(r[10:0], sh[5]);
    xfer(16, 1'b1, 4'he, 11'h000);
    chk(r[10:0], 11'h000);
    xfer(16, 1'b0, 4'hc, 11'h001);
    sh[12] = 11'h001;
    GATE_EN <= 1'b1;
    cyc(8);
    chk({GATE_DRIVE_EN, AMP_EN, PULLDOWN_EN}, 11'h006);
    for (int i = 0; i < 3; i++) begin
      d = {8'($random(seed)), ms[i]};
      xfer(16, 1'b0, 4'hc, d);
      sh[12] = {d[10:3], exp_mode(sh[12][2:0], d[2:0])};
      cyc(2);
      chk({DRAIN_OC_THRESHOLD, DRAIN_OC_MODE}, sh[12]);
      chk(GATE_DRIVE_EN, 11'h001);
    end
    xfer(16, 1'b0, 4'h9, 11'h004);
    cyc(100);
    chk({GATE_DRIVE_EN, REGULATOR_EN}, 11'h003);
    REG_UNDERVOLTAGE_DET <= 1'b1;
    cyc(10);
    chk({GATE_DRIVE_EN, FAULT_OUT_N, POWER_GOOD_OUT, PULLDOWN_EN}, 11'h001);
    xfer(16, 1'b1, 4'h3, 11'h000);
    chk(r[6], 11'h001);
    REG_UNDERVOLTAGE_DET <= 1'b0;
    pg_wait;
    chk(n >= sfc_pkg::PG_LOW_CYC, 11'h001);
    chk(FAULT_OUT_N, 11'h000);
    xfer(16, 1'b0, 4'h9, 11'h002);
    cyc(4);
    chk({FAULT_OUT_N, GATE_DRIVE_EN}, 11'h002);
    xfer(16, 1'b1, 4'h9, 11'h000);
    chk(r[1], 11'h000);
    REG_UNDERVOLTAGE_DET <= 1'b1;
    cyc(10);
    REG_UNDERVOLTAGE_DET <= 1'b0;
    pg_wait;
    chk(FAULT_OUT_N, 11'h000);
    GATE_EN <= 1'b0;
    cyc(60);
    GATE_EN <= 1'b1;
    cyc(10);
    chk(FAULT_OUT_N, 11'h001);
    GATE_EN <= 1'b0;
    xfer(16, 1'b0, 4'hb, 11'h004);
    REG_UNDERVOLTAGE_DET <= 1'b1;
    cyc(10);
    chk({POWER_GOOD_OUT, FAULT_OUT_N}, 11'h003);
    REG_UNDERVOLTAGE_DET <= 1'b0;
    xfer(16, 1'b0, 4'h9, 11'h100);
    GATE_FAULT_DET <= 1'b1;
    cyc(10);
    xfer(16, 1'b1, 4'h4, 11'h000);
    chk({r[10], FAULT_OUT_N}, 11'h001);
    xfer(16, 1'b0, 4'h9, 11'h000);
    cyc(10);
    chk(FAULT_OUT_N, 11'h000);
    GATE_FAULT_DET <= 1'b0;
    xfer(16, 1'b0, 4'h9, 11'h002);
    cyc(4);
    chk(FAULT_OUT_N, 11'h001);
    xfer(16, 1'b0, 4'h5, 11'h2aa);
    sel = 2'($random(seed));
    e = (int'(sel) + 1) * UNIT;
    xfer(16, 1'b0, 4'hb, {6'h00, sel, 3'h0});
    xfer(16, 1'b0, 4'h9, 11'h004);
    n = 0;
    while (REGULATOR_EN === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk(n + 8 >= e && n <= e + 8, 11'h001);
    cyc(2);
    chk(HS_GATE_CFG, 11'h000);
    chk(GATE_DRIVE_EN, 11'h000);
    WAKE <= 1'b1;
    DRIVER_SUPPLY_LOCKOUT_OK <= 1'b0;
    cyc(20);
    chk(REGULATOR_EN, 11'h000);
    DRIVER_SUPPLY_LOCKOUT_OK <= 1'b1;
    cyc(20);
    chk(REGULATOR_EN, 11'h001);
    WAKE <= 1'b0;
    cyc(20);
    chk({FAULT_OUT_N, SPI_DATA_OUT_OE}, 11'h002);
    complete_run;
  end
endmodule
